// ### rtl/scrc_pkg.sv
// package: register map and constants of the serial channel run and output control block
// Notes on behaviour
// - start bit one sets channel enable
// - halt bit one clears enable, stops
// - start during transfer aborts, keeps state
// - stop keeps config, shift, pins, errors
// - start trigger register reads zero
// - stop trigger register reads zero
// - enabled channel: engine drives clock pin
// - stopped channel: software drives clock pin
// - output enable selects engine or software data
// - data bit write ignored while enabled output
// - clock bit write ignored while channel enabled
// - buffer layout bits 9,8,1,0; reset 0303
// - each buffer bit drives its own pin
// - enable status read-only, resets zero
// - start or stop clears active, full flags
package scrc_pkg;
  localparam int          SCRC_NCH        = 2;
  localparam int          SCRC_AW         = 20;
  localparam logic [19:0] SCRC_ENA_STAT   = 20'hf0120;
  localparam logic [19:0] SCRC_START_TRIG = 20'hf0122;
  localparam logic [19:0] SCRC_STOP_TRIG  = 20'hf0124;
  localparam logic [19:0] SCRC_PIN_BUF    = 20'hf0128;
  localparam logic [19:0] SCRC_DOUT_ENA   = 20'hf012a;
  localparam int          SCRC_CLK_POS    = 8;
  localparam int          SCRC_DAT_POS    = 0;
  localparam logic [15:0] SCRC_PIN_RST    = 16'h0303;
  localparam logic [15:0] SCRC_ZERO_RST   = 16'h0000;
endpackage

// ### rtl/scrc_trig_if.sv
// interface: per-channel trigger pulses between the decoder and the channel bank
`timescale 1ns/1ns
interface scrc_trig_if;
  logic [1:0] start;
  logic [1:0] halt;
  logic [1:0] enabled;
  modport src (output start, output halt, input enabled);
  modport dst (input start, input halt, output enabled);
endinterface

// ### rtl/scrc_chan_bank.sv
// module: enable status flops of both channels
`timescale 1ns/1ns
module scrc_chan_bank
  import scrc_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst,
  scrc_trig_if.dst     trig
);
  logic [1:0] ena_q;
  logic [1:0] ena_d;
  // stop wins over start when both land together
  assign ena_d = (ena_q | trig.start) & ~trig.halt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ena_q <= 2'h0;
    end else begin
      ena_q <= ena_d;
    end
  end
  assign trig.enabled = ena_q;

  start_sets_a: assert property (@(posedge clk) disable iff (rst)
    (trig.start[0] && !trig.halt[0]) |=> ena_q[0]) else $error("start did not enable");
  halt_clears_a: assert property (@(posedge clk) disable iff (rst)
    trig.halt[1] |=> !ena_q[1]) else $error("halt did not disable");
endmodule // scrc_chan_bank

// ### rtl/scrc_ctrl.sv
// module: top of the serial channel run and output control registers
`timescale 1ns/1ns
module scrc_ctrl
  import scrc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // cpu memory bus, 16-bit word access
  input  wire logic [19:0] addr,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  // communication engine side
  input  wire logic [1:0]  eng_clk_out,
  input  wire logic [1:0]  eng_dat_out,
  output logic      [1:0]  chan_enable,
  output logic      [1:0]  chan_abort,
  output logic      [1:0]  dout_enable,
  // pins
  output logic      [1:0]  serial_clock_pin,
  output logic      [1:0]  serial_data_pin
);
  //--------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------
  function automatic logic hit(input logic [19:0] a, input logic [19:0] off);
    hit = (a == off);
  endfunction

  wire wr_start = wr && hit(addr, SCRC_START_TRIG);
  wire wr_stop  = wr && hit(addr, SCRC_STOP_TRIG);
  wire wr_pin   = wr && hit(addr, SCRC_PIN_BUF);
  wire wr_oe    = wr && hit(addr, SCRC_DOUT_ENA);

  scrc_trig_if trig ();
  // trigger bits are not stored: they act once and read back zero
  assign trig.start = wr_start ? wdata[1:0] : 2'h0;
  assign trig.halt  = wr_stop  ? wdata[1:0] : 2'h0;

  scrc_chan_bank u_bank (
    .clk  (clk),
    .rst  (rst),
    .trig (trig)
  );

  //--------------------------------------------------------------
  // output enable and pin buffer
  //--------------------------------------------------------------
  logic [1:0] oe_q;
  logic [1:0] ck_q;
  logic [1:0] so_q;
  logic [1:0] ck_d;
  logic [1:0] so_d;

  // software write only where hardware has not taken the bit
  genvar g;
  generate
    for (g = 0; g < SCRC_NCH; g++) begin : g_ch
      assign ck_d[g] = trig.enabled[g] ? eng_clk_out[g] :
                       (wr_pin ? wdata[SCRC_CLK_POS+g] : ck_q[g]);
      assign so_d[g] = oe_q[g] ? eng_dat_out[g] :
                       (wr_pin ? wdata[SCRC_DAT_POS+g] : so_q[g]);
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oe_q <= SCRC_ZERO_RST[1:0];
      ck_q <= SCRC_PIN_RST[SCRC_CLK_POS+:2];
      so_q <= SCRC_PIN_RST[SCRC_DAT_POS+:2];
    end else begin
      if (wr_oe) begin
        oe_q <= wdata[1:0];
      end
      ck_q <= ck_d;
      so_q <= so_d;
    end
  end

  //--------------------------------------------------------------
  // read data and registered outputs
  //--------------------------------------------------------------
  logic [15:0] rd_mux;
  // trigger registers fall through to zero
  assign rd_mux = !rd                         ? 16'h0000 :
                  hit(addr, SCRC_ENA_STAT)    ? {14'h0000, trig.enabled} :
                  hit(addr, SCRC_PIN_BUF)     ? {6'h00, ck_q, 6'h00, so_q} :
                  hit(addr, SCRC_DOUT_ENA)    ? {14'h0000, oe_q} : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata            <= 16'h0000;
      chan_enable      <= 2'h0;
      chan_abort       <= 2'h0;
      dout_enable      <= 2'h0;
      serial_clock_pin <= 2'h3;
      serial_data_pin  <= 2'h3;
    end else begin
      rdata            <= rd_mux;
      chan_enable      <= trig.enabled;
      // abort pulse tells engine to clear active and full flags, keep the rest
      chan_abort       <= trig.start | trig.halt;
      dout_enable      <= oe_q;
      serial_clock_pin <= ck_q;
      serial_data_pin  <= so_q;
    end
  end

  ck_locked_a: assert property (@(posedge clk) disable iff (rst)
    (trig.enabled[0] && wr_pin) |=> ck_q[0] == $past(eng_clk_out[0])) else $error("clock bit written while enabled");
  so_locked_a: assert property (@(posedge clk) disable iff (rst)
    (oe_q[1] && !wr_oe) |=> so_q[1] == $past(eng_dat_out[1])) else $error("data bit not from engine");
  so_written_a: assert property (@(posedge clk) disable iff (rst)
    (!oe_q[0] && wr_pin) |=> so_q[0] == $past(wdata[0])) else $error("data bit write lost");
  ck_written_a: assert property (@(posedge clk) disable iff (rst)
    (!trig.enabled[1] && !trig.start[1] && wr_pin) |=> ck_q[1] == $past(wdata[9])) else $error("clock write lost");
  pin_follow_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> serial_data_pin == $past(so_q)) else $error("pin mismatch");
  trig_zero_a: assert property (@(posedge clk) disable iff (rst)
    (rd && (hit(addr, SCRC_START_TRIG) || hit(addr, SCRC_STOP_TRIG))) |=> rdata == 16'h0000) else $error("trigger read nonzero");
  abort_pulse_a: assert property (@(posedge clk) disable iff (rst)
    (trig.start[0] || trig.halt[0]) |=> chan_abort[0]) else $error("abort missing");
  stat_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd && hit(addr, SCRC_ENA_STAT)) |=> rdata == {14'h0000, $past(trig.enabled)}) else $error("status read wrong");
endmodule // scrc_ctrl

// ### tb/scrc_eng_peer.sv
// partner: engine stub feeding levels into the block
`timescale 1ns/1ns
module scrc_eng_peer (
  input  wire logic [1:0] lvl,
  output logic      [1:0] eng_clk_out,
  output logic      [1:0] eng_dat_out
);
  // steady levels so every follow is predictable
  assign eng_clk_out = lvl;
  assign eng_dat_out = ~lvl;
endmodule // scrc_eng_peer

// ### tb/tb_serial_channel_run_and_output_control.sv
// testbench: register model compared with the control block
`timescale 1ns/1ns
module tb_serial_channel_run_and_output_control import scrc_pkg::*;;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [19:0] addr = '0;
  logic [15:0] wdata = '0, rdata, so = 16'h0303;
  logic [1:0]  lvl = '0, ec, ed, ce, ca, de, cp, dp, se = '0, soe = '0;
  int          n_mismatch = 0, compares = 0, n_ab = 0, x_ab = 0;
  logic [19:0] regs [5] = '{SCRC_ENA_STAT, SCRC_START_TRIG, SCRC_STOP_TRIG, SCRC_PIN_BUF, SCRC_DOUT_ENA};
  always #5 clk = ~clk;
  always @(posedge clk) n_ab <= n_ab + $countones(ca);
  scrc_ctrl dut_u (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
    .eng_clk_out(ec), .eng_dat_out(ed), .chan_enable(ce), .chan_abort(ca), .dout_enable(de),
    .serial_clock_pin(cp), .serial_data_pin(dp));
  scrc_eng_peer peer_u (.lvl(lvl), .eng_clk_out(ec), .eng_dat_out(ed));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [19:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  // engine-owned bits track the stub while their owner is on
  function automatic void upd();
    for (int j = 0; j < 2; j++) begin
      if (se[j]) so[8+j] = lvl[j];
      if (soe[j]) so[j] = ~lvl[j];
    end
  endfunction
  task automatic wrm(input logic [19:0] a, input logic [15:0] d);
    upd();
    acc(1'b1, a, d);
    for (int j = 0; j < 2; j++) begin
      if (a == SCRC_PIN_BUF && !soe[j]) so[j] = d[j];
      if (a == SCRC_PIN_BUF && !se[j]) so[8+j] = d[8+j];
      if (a == SCRC_START_TRIG && d[j]) se[j] = 1'b1;
      if (a == SCRC_STOP_TRIG && d[j]) se[j] = 1'b0;
    end
    if (a == SCRC_DOUT_ENA) soe = d[1:0];
    if (a == SCRC_START_TRIG || a == SCRC_STOP_TRIG) x_ab += $countones(d[1:0]);
    upd();
    repeat (3) @(negedge clk);
  endtask
  task automatic chkall();
    logic [15:0] ex [5];
    ex = '{{14'h0, se}, 16'h0, 16'h0, so, {14'h0, soe}};
    foreach (regs[i]) begin
      acc(1'b0, regs[i], 16'h0);
      chk("register", ex[i], rdata);
    end
    acc(1'b0, 20'hf0126, 16'h0);
    chk("unmapped", 16'h0, rdata);
    chk("pins", {so[9:8], so[1:0]}, {cp, dp});
    chk("enables", {soe, se}, {de, ce});
  endtask
  task automatic print_verdict();
    $display("counts: compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    logic [19:0] a;
    logic [15:0] d;
    void'($urandom(32'h215d099e));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chkall();
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      @(negedge clk);
      lvl = 2'($urandom);
      // at least four idle clocks before any start trigger
      repeat (2) @(negedge clk);
      a = regs[1 + $urandom % 4];
      // unused bits kept zero by software
      d = 16'($urandom) & (a == SCRC_PIN_BUF ? 16'h0303 : 16'h0003);
      wrm(a, d);
      chkall();
    end
    $display("test random done");
    wrm(20'hf0126, 16'hffff);
    wrm(SCRC_ENA_STAT, 16'h0003);
    chkall();
    $display("test refused done");
    chk("abort pulses", 16'(x_ab), 16'(n_ab));
    print_verdict();
  end
endmodule // tb_serial_channel_run_and_output_control
